// file: core/dac_consts.svh
`ifndef DAC_CONSTS_SVH
`define DAC_CONSTS_SVH

// register offsets, one byte each
`define ADDR_CTRL 3'h0
`define ADDR_HIGH 3'h1
`define ADDR_LOW 3'h2
`define ADDR_CMPSTAT 3'h3
`define ADDR_CMP0CTL 3'h4
`define ADDR_CMP1CTL 3'h5

// converter_control fields
`define CTRL_ATE 7
`define CTRL_TS_HI 6
`define CTRL_TS_LO 4
`define CTRL_LA 2
`define CTRL_OE 1
`define CTRL_EN 0
`define CTRL_WMASK 8'hF7
`define CTRL_RESET 8'h00

// trigger source codes
`define TS_CMP0 3'h0

// comparator control fields
`define CMPC_IE 6
`define CMPC_IS_HI 5
`define CMPC_IS_LO 4
`define CMPC_WMASK 8'h70

// comparator status fields
`define STAT_F1 5
`define STAT_F0 4

// sensitivity codes
`define SENS_TOGGLE 2'h0
`define SENS_FALL 2'h2
`define SENS_RISE 2'h3

// conversion window
`define CLK_PERIOD_NS 10
`define CONV_TIME_NS 1000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: core/dac_pkg.sv
package dac_pkg;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } busReq_t;

   typedef struct packed {
      logic tim1Capt;
      logic tim1Ovf;
      logic tim1CmpB;
      logic tim0Ovf;
      logic tim0Cmp;
      logic extInt0;
   } trigSources_t;

endpackage

// file: core/cmp_event_flag.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_consts.svh"

module cmp_event_flag (
   input wire logic clk,
   input wire logic resetn,
   input wire logic cmpLevel,
   input wire logic [1:0] sensitivity,
   input wire logic clearWrite,
   input wire logic vectorAck,
   input wire logic irqEnable,
   output logic flag
);

   logic prev_r;
   logic flag_r;

   wire isRise = cmpLevel & ~prev_r;
   wire isFall = ~cmpLevel & prev_r;
   // code 01 is reserved and never fires
   wire evt = (sensitivity == `SENS_TOGGLE) ? (isRise | isFall) :
              (sensitivity == `SENS_FALL) ? isFall :
              (sensitivity == `SENS_RISE) ? isRise : 1'b0;
   // vector clears only when the interrupt is enabled
   wire clr = clearWrite | (vectorAck & irqEnable); // R14 R15
   // set beats clear in the same cycle
   wire flag_nxt = evt | (flag_r & ~clr); // R12 R13 R9

   always_ff @(posedge clk) begin
      if (!resetn) begin
         prev_r <= 1'b0;
         flag_r <= 1'b0;
      end else begin
         prev_r <= cmpLevel;
         flag_r <= flag_nxt;
      end
   end

   assign flag = flag_r;

   AST_EVENT_SETS: // R12
   assert property (@(posedge clk) disable iff (!resetn) evt |=> flag_r)
      else $error("event did not set flag");

   AST_W1C_CLEARS: // R15
   assert property (@(posedge clk) disable iff (!resetn)
      (clearWrite && !evt) |=> !flag_r)
      else $error("write one did not clear flag");

   AST_VECTOR_NEEDS_IE: // R14
   assert property (@(posedge clk) disable iff (!resetn)
      (flag_r && vectorAck && !irqEnable && !clearWrite) |=> flag_r)
      else $error("flag cleared by vector while disabled");

endmodule // cmp_event_flag

`default_nettype wire

// file: core/dac_trigger_and_update_control.sv
// Function
// R1: converter input value is ten bits
// R2: control, high and low value registers
// R3: control layout ate,ts,rsvd,la,oe,en; reset zero
// R4: enable converts held value with settings
// R5: auto-trigger bit selects event-driven updating
// R6: rising trigger edge starts conversion
// R7: trigger still high: no new conversion
// R8: edges during conversion are dropped
// R9: event flags set regardless of interrupt enable
// R10: software clears flag before next trigger
// R11: manual mode updates on high write
// R12: comparator 1 flag set per sensitivity
// R13: comparator 0 flag set per sensitivity
// R14: vector clears flag only if enabled
// R15: writing one clears a comparator flag
// R16: comparator flags usable as triggers
// R17: status low bits mirror comparator outputs
// R18: source select maps eight event sources
// R19: low write waits for high write
// R20: left adjust chooses value byte layout
// R21: output enable routes result to pin
// R22: fixed busy window after each update
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "dac_consts.svh"

module dac_trigger_and_update_control (
   input wire logic clk,
   input wire logic resetn,
   input wire dac_pkg::busReq_t busReq,
   output logic [7:0] rdata,
   input wire dac_pkg::trigSources_t trigSrc,
   input wire logic [3:0] cmpOut,
   input wire logic cmp0VectorAck,
   input wire logic cmp1VectorAck,
   output logic [9:0] dacValue,
   output logic dacEnabled,
   output logic analogOutEnable,
   output logic convBusy,
   output logic updatePulse,
   output logic [1:0] cmpFlags
);

   function automatic logic wrHit(input dac_pkg::busReq_t r, input logic [2:0] a);
      return r.we && (r.addr == a);
   endfunction

   function automatic logic rdHit(input dac_pkg::busReq_t r, input logic [2:0] a);
      return r.re && (r.addr == a);
   endfunction

   // byte layout of the ten-bit code
   function automatic logic [9:0] packValue(input logic la, input logic [7:0] hi,
                                            input logic [7:0] lo);
      return la ? {hi, lo[7:6]} : {hi[1:0], lo}; // R20
   endfunction

   logic [7:0] ctrl_r;
   logic [7:0] high_r;
   logic [7:0] low_r;
   logic [7:0] cmp0Ctl_r;
   logic [7:0] cmp1Ctl_r;
   logic [7:0] rdata_r;
   logic [3:0] cmpMeta_r;
   logic [3:0] cmpSync_r;
   logic [9:0] staged_r;
   logic [9:0] value_r;
   logic trigPrev_r;
   logic [7:0] busyCnt_r;
   logic [7:0] busyCnt_nxt;
   logic busy_r;
   logic upd_r;
   logic enOut_r;
   logic oeOut_r;
   logic [1:0] flagOut_r;
   logic [1:0] flag;

   // bus decode
   wire wrCtrl = wrHit(busReq, `ADDR_CTRL);
   wire wrHigh = wrHit(busReq, `ADDR_HIGH);
   wire wrLow = wrHit(busReq, `ADDR_LOW);
   wire wrStat = wrHit(busReq, `ADDR_CMPSTAT);
   wire wrC0 = wrHit(busReq, `ADDR_CMP0CTL);
   wire wrC1 = wrHit(busReq, `ADDR_CMP1CTL);

   wire reCtrl = rdHit(busReq, `ADDR_CTRL);
   wire reHigh = rdHit(busReq, `ADDR_HIGH);
   wire reLow = rdHit(busReq, `ADDR_LOW);
   wire reStat = rdHit(busReq, `ADDR_CMPSTAT);
   wire reC0 = rdHit(busReq, `ADDR_CMP0CTL);
   wire reC1 = rdHit(busReq, `ADDR_CMP1CTL);

   wire autoMode = ctrl_r[`CTRL_ATE]; // R5
   wire enabled = ctrl_r[`CTRL_EN];
   wire leftAdj = ctrl_r[`CTRL_LA];
   wire [2:0] trigSel = ctrl_r[`CTRL_TS_HI:`CTRL_TS_LO];

   // comparator event flags
   wire clr0 = wrStat & busReq.wdata[`STAT_F0]; // R15
   wire clr1 = wrStat & busReq.wdata[`STAT_F1]; // R15

   cmp_event_flag u_flag0 (
      .clk(clk),
      .resetn(resetn),
      .cmpLevel(cmpSync_r[0]),
      .sensitivity(cmp0Ctl_r[`CMPC_IS_HI:`CMPC_IS_LO]),
      .clearWrite(clr0),
      .vectorAck(cmp0VectorAck),
      .irqEnable(cmp0Ctl_r[`CMPC_IE]),
      .flag(flag[0])
   ); // R13

   cmp_event_flag u_flag1 (
      .clk(clk),
      .resetn(resetn),
      .cmpLevel(cmpSync_r[1]),
      .sensitivity(cmp1Ctl_r[`CMPC_IS_HI:`CMPC_IS_LO]),
      .clearWrite(clr1),
      .vectorAck(cmp1VectorAck),
      .irqEnable(cmp1Ctl_r[`CMPC_IE]),
      .flag(flag[1])
   ); // R12

   // trigger source table, index equals select code
   wire [7:0] trigVec = {trigSrc.tim1Capt, trigSrc.tim1Ovf, trigSrc.tim1CmpB,
                         trigSrc.tim0Ovf, trigSrc.tim0Cmp, trigSrc.extInt0,
                         flag[1], flag[0]}; // R18 R16
   wire selTrig = trigVec[trigSel];

   // edge, not level: a flag left high never retriggers
   wire trigRise = selTrig & ~trigPrev_r; // R6 R7
   wire busyNow = (busyCnt_r != 8'h00);
   // no pending record kept, an edge seen while busy is lost
   wire trigFire = autoMode & enabled & trigRise & ~busyNow; // R6 R8 R4
   wire writeUpdate = ~autoMode & wrHigh; // R11
   wire update = writeUpdate | trigFire;

   // layout taken at the high write, so a late la change waits for it
   wire [9:0] wrValue = packValue(leftAdj, busReq.wdata, low_r); // R20 R1
   wire [9:0] newValue = writeUpdate ? wrValue : staged_r;

   assign busyCnt_nxt = update ? 8'(`CONV_CYCLES) :
                        busyNow ? busyCnt_r - 8'h01 : busyCnt_r; // R22

   // read mux, unmapped addresses read zero
   wire [7:0] statRd = {2'h0, flag[1], flag[0], cmpSync_r}; // R17
   wire [7:0] rdNxt = reCtrl ? (ctrl_r & `CTRL_WMASK) :
                      reHigh ? high_r :
                      reLow ? low_r :
                      reStat ? statRd :
                      reC0 ? cmp0Ctl_r :
                      reC1 ? cmp1Ctl_r : 8'h00;

   // comparator outputs are asynchronous to clk
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cmpMeta_r <= 4'h0;
         cmpSync_r <= 4'h0;
      end else begin
         cmpMeta_r <= cmpOut;
         cmpSync_r <= cmpMeta_r;
      end
   end

   // software registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_r <= `CTRL_RESET; // R3
         high_r <= 8'h00;
         low_r <= 8'h00;
         cmp0Ctl_r <= 8'h00;
         cmp1Ctl_r <= 8'h00;
      end else begin
         if (wrCtrl) begin
            ctrl_r <= busReq.wdata & `CTRL_WMASK; // R3
         end
         if (wrHigh) begin
            high_r <= busReq.wdata; // R2
         end
         if (wrLow) begin
            low_r <= busReq.wdata; // R2
         end
         if (wrC0) begin
            cmp0Ctl_r <= busReq.wdata & `CMPC_WMASK;
         end
         if (wrC1) begin
            cmp1Ctl_r <= busReq.wdata & `CMPC_WMASK;
         end
      end
   end

   // staged copy only moves on a high write
   always_ff @(posedge clk) begin
      if (!resetn) begin
         staged_r <= 10'h000;
      end else if (wrHigh) begin
         staged_r <= wrValue; // R19
      end
   end

   // converted value and conversion window
   always_ff @(posedge clk) begin
      if (!resetn) begin
         value_r <= 10'h000;
         trigPrev_r <= 1'b0;
         busyCnt_r <= 8'h00;
         busy_r <= 1'b0;
         upd_r <= 1'b0;
      end else begin
         if (update) begin
            value_r <= newValue; // R4 R11 R6
         end
         trigPrev_r <= selTrig;
         busyCnt_r <= busyCnt_nxt; // R22
         busy_r <= (busyCnt_nxt != 8'h00);
         upd_r <= update;
      end
   end

   // outputs straight from flops
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_r <= 8'h00;
         enOut_r <= 1'b0;
         oeOut_r <= 1'b0;
         flagOut_r <= 2'h0;
      end else begin
         rdata_r <= rdNxt;
         enOut_r <= enabled; // R4
         oeOut_r <= enabled & ctrl_r[`CTRL_OE]; // R21
         flagOut_r <= flag;
      end
   end

   assign rdata = rdata_r;
   assign dacValue = value_r;
   assign dacEnabled = enOut_r;
   assign analogOutEnable = oeOut_r;
   assign convBusy = busy_r;
   assign updatePulse = upd_r;
   assign cmpFlags = flagOut_r;

   AST_TRIG_UPDATES: // R6
   assert property (@(posedge clk) disable iff (!resetn)
      (autoMode && enabled && selTrig && !trigPrev_r && !busyNow)
      |=> upd_r && (value_r == $past(staged_r)))
      else $error("rising trigger did not update value");

   AST_EDGE_IGNORED_BUSY: // R8
   assert property (@(posedge clk) disable iff (!resetn)
      (autoMode && busyNow && !wrCtrl) |=> !upd_r)
      else $error("update while conversion in progress");

   AST_LEVEL_NO_RETRIG: // R7
   assert property (@(posedge clk) disable iff (!resetn)
      (autoMode && selTrig && trigPrev_r && !wrCtrl) |=> !upd_r)
      else $error("held trigger started a conversion");

   AST_WRITE_UPDATES: // R11
   assert property (@(posedge clk) disable iff (!resetn)
      (wrHigh && !autoMode)
      |=> upd_r && (value_r == packValue($past(leftAdj), $past(busReq.wdata),
                                         $past(low_r))))
      else $error("high write did not update value");

   AST_LOW_WAITS: // R19
   assert property (@(posedge clk) disable iff (!resetn)
      (wrLow && !trigFire) |=> $stable(value_r))
      else $error("low write reached converted value");

   AST_BUSY_HOLDS: // R22
   assert property (@(posedge clk) disable iff (!resetn)
      $rose(busy_r) |-> busy_r[*8])
      else $error("busy window too short");

   AST_BUSY_ENDS: // R22
   assert property (@(posedge clk) disable iff (!resetn)
      $fell(busy_r) |-> ($past(busyCnt_r) == 8'h01))
      else $error("busy ended early");

   AST_STATUS_MIRROR: // R17
   assert property (@(posedge clk) disable iff (!resetn)
      reStat |=> (rdata_r[3:0] == $past(cmpSync_r)) && (rdata_r[7:6] == 2'h0))
      else $error("status does not mirror comparators");

   AST_CTRL_RSVD: // R3
   assert property (@(posedge clk) disable iff (!resetn)
      reCtrl |=> !rdata_r[3])
      else $error("reserved control bit read as one");

   AST_PIN_ROUTE: // R21
   assert property (@(posedge clk) disable iff (!resetn)
      (wrCtrl && !busReq.wdata[`CTRL_OE]) |=> ##1 !oeOut_r)
      else $error("output driven with output enable clear");

   AST_RDATA_IDLE: // R2
   assert property (@(posedge clk) disable iff (!resetn)
      !busReq.re |=> (rdata_r == 8'h00))
      else $error("read data not zero outside a read");

   AST_HIGH_READBACK: // R2
   assert property (@(posedge clk) disable iff (!resetn)
      reHigh |=> (rdata_r == $past(high_r)))
      else $error("high value byte read back wrong");

   AST_LOW_READBACK: // R2
   assert property (@(posedge clk) disable iff (!resetn)
      reLow |=> (rdata_r == $past(low_r)))
      else $error("low value byte read back wrong");

   AST_ENABLE_FOLLOWS: // R4
   assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> (enOut_r == $past(enabled)))
      else $error("enable output does not follow control");

   AST_DRIVE_NEEDS_EN: // R21
   assert property (@(posedge clk) disable iff (!resetn)
      !enabled |=> !oeOut_r)
      else $error("pin driven while converter disabled");

   AST_FLAG_OUTPUTS: // R12 R13
   assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> (flagOut_r == $past(flag)))
      else $error("flag outputs do not follow flags");

   AST_NO_TRIG_DISABLED: // R4
   assert property (@(posedge clk) disable iff (!resetn)
      (autoMode && !enabled) |=> !upd_r)
      else $error("trigger update while disabled");

   AST_VALUE_HELD: // R19
   assert property (@(posedge clk) disable iff (!resetn)
      !update |=> $stable(value_r))
      else $error("converted value moved without update");

   AST_STAGE_HELD: // R19
   assert property (@(posedge clk) disable iff (!resetn)
      !wrHigh |=> $stable(staged_r))
      else $error("staged value moved without high write");

   AST_LEFT_LAYOUT: // R20
   assert property (@(posedge clk) disable iff (!resetn)
      (wrHigh && leftAdj) |=> (staged_r == {$past(busReq.wdata), $past(low_r[7:6])}))
      else $error("left adjusted layout wrong");

   AST_RIGHT_LAYOUT: // R20
   assert property (@(posedge clk) disable iff (!resetn)
      (wrHigh && !leftAdj) |=> (staged_r == {$past(busReq.wdata[1:0]), $past(low_r)}))
      else $error("right adjusted layout wrong");

   AST_SEL_CMP0: // R16 R18
   assert property (@(posedge clk) disable iff (!resetn)
      (trigSel == `TS_CMP0) |-> (selTrig == flag[0]))
      else $error("comparator 0 flag not selected as trigger");

endmodule // dac_trigger_and_update_control

`default_nettype wire

// file: tb/event_source_model.sv
`timescale 1ns/1ps
`default_nettype none

module event_source_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [5:0] setEvt,
   input wire logic [5:0] clrEvt,
   output dac_pkg::trigSources_t flags
);
   logic [5:0] flags_r;

   // set wins over a clear in the same cycle, like a real flag
   always_ff @(posedge clk) begin
      if (!resetn) begin
         flags_r <= 6'h00;
      end else begin
         flags_r <= (flags_r & ~clrEvt) | setEvt;
      end
   end

   assign flags = flags_r;
endmodule // event_source_model

`default_nettype wire

// file: tb/dac_trigger_and_update_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_consts.svh"

module dac_trigger_and_update_control_test;
   logic clk;
   logic resetn;
   dac_pkg::busReq_t busReq;
   logic [7:0] rdata;
   dac_pkg::trigSources_t trigSrc;
   logic [3:0] cmpOut;
   logic cmp0VectorAck;
   logic cmp1VectorAck;
   logic [9:0] dacValue;
   logic dacEnabled;
   logic analogOutEnable;
   logic convBusy;
   logic updatePulse;
   logic [1:0] cmpFlags;
   logic [5:0] setEvt;
   logic [5:0] clrEvt;
   logic [9:0] expVal;
   int expUpd = 0;
   int updates = 0;
   int cycles = 0;
   int mismatches = 0;
   int tests_run = 0;

   dac_trigger_and_update_control dut (
      .clk(clk), .resetn(resetn), .busReq(busReq), .rdata(rdata), .trigSrc(trigSrc),
      .cmpOut(cmpOut), .cmp0VectorAck(cmp0VectorAck), .cmp1VectorAck(cmp1VectorAck),
      .dacValue(dacValue), .dacEnabled(dacEnabled), .analogOutEnable(analogOutEnable),
      .convBusy(convBusy), .updatePulse(updatePulse), .cmpFlags(cmpFlags)
   );

   event_source_model sources (
      .clk(clk), .resetn(resetn), .setEvt(setEvt), .clrEvt(clrEvt), .flags(trigSrc)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // run is well under 3000 cycles; the ceiling only catches a hang
   always @(posedge clk) begin
      cycles++;
      if (updatePulse === 1'b1) begin
         updates++;
      end
      if (cycles == 6000) begin
         mismatches++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk);
      busReq.we <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      busReq <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge clk);
      busReq.re <= 1'b0;
      #1;
      check(what, {2'b00, exp}, {2'b00, rdata});
   endtask

   task automatic pulse_evt(input int idx, input logic clr);
      @(posedge clk);
      if (clr) clrEvt <= 6'h01 << idx;
      else setEvt <= 6'h01 << idx;
      @(posedge clk);
      clrEvt <= 6'h00;
      setEvt <= 6'h00;
   endtask

   initial begin
      busReq = '0;
      setEvt = 6'h00;
      clrEvt = 6'h00;
      cmpOut = 4'h0;
      cmp0VectorAck = 1'b0;
      cmp1VectorAck = 1'b0;
      resetn = 1'b0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      rd(3'h0, 8'h00, "ctrl reset");
      wr(3'h6, 8'hFF);
      rd(3'h6, 8'h00, "unmapped");
      wr(3'h0, 8'hFF);
      rd(3'h0, 8'hF7, "ctrl reserved");
      wr(3'h0, 8'h03);
      tick(2);
      check("enables", 10'h003, {8'h00, analogOutEnable, dacEnabled});
      wr(3'h0, 8'h02);
      tick(2);
      check("drive needs enable", 10'h000, {8'h00, analogOutEnable, dacEnabled});
      wr(3'h0, 8'h01);
      tick(2);
      check("drive off", 10'h001, {8'h00, analogOutEnable, dacEnabled});
      $display("test registers done");
      wr(3'h2, 8'hA5);
      tick(2);
      check("low only", 10'h000, dacValue);
      wr(3'h1, 8'h02);
      tick(1);
      check("right adjust", 10'h2A5, dacValue);
      check("manual pulse", 10'h001, 10'(updates));
      tick(`CONV_CYCLES - 3);
      check("busy window", 10'h001, {9'h000, convBusy});
      tick(2);
      check("busy over", 10'h000, {9'h000, convBusy});
      wr(3'h0, 8'h05);
      wr(3'h2, 8'h40);
      wr(3'h1, 8'h81);
      tick(1);
      check("left adjust", 10'h205, dacValue);
      expVal = 10'h205;
      expUpd = 2;
      tick(`CONV_CYCLES);
      $display("test manual done");
      for (int s = 2; s < 8; s++) begin
         wr(3'h0, {1'b1, 3'(s), 4'h1});
         wr(3'h2, 8'(s * 16 + 1));
         wr(3'h1, 8'h01);
         tick(2);
         check("held before trigger", expVal, dacValue);
         pulse_evt(s - 2, 1'b0);
         tick(4);
         expVal = {2'b01, 8'(s * 16 + 1)};
         expUpd++;
         check("triggered value", expVal, dacValue);
         pulse_evt(s - 2, 1'b1);
         pulse_evt(s - 2, 1'b0);
         tick(`CONV_CYCLES + 10);
         check("edge in busy", 10'(expUpd), 10'(updates));
         pulse_evt(s - 2, 1'b1);
      end
      wr(3'h0, 8'hA0);
      pulse_evt(0, 1'b0);
      tick(4);
      check("disabled", 10'(expUpd), 10'(updates));
      pulse_evt(0, 1'b1);
      wr(3'h0, 8'h21);
      pulse_evt(0, 1'b0);
      tick(4);
      check("manual ignores edge", 10'(expUpd), 10'(updates));
      pulse_evt(0, 1'b1);
      $display("test triggers done");
      wr(3'h4, 8'h30);
      wr(3'h5, 8'h20);
      wr(3'h0, 8'h81);
      @(posedge clk);
      cmpOut <= 4'hB;
      tick(8);
      rd(3'h3, 8'h1B, "cmp0 rise");
      check("flag out", 10'h001, {8'h00, cmpFlags});
      check("cmp trigger", 10'(expUpd + 1), 10'(updates));
      @(posedge clk);
      cmpOut <= 4'h8;
      tick(8);
      rd(3'h3, 8'h38, "cmp1 fall");
      wr(3'h3, 8'h00);
      rd(3'h3, 8'h38, "write zero");
      wr(3'h3, 8'h10);
      rd(3'h3, 8'h28, "write one");
      @(posedge clk);
      cmp1VectorAck <= 1'b1;
      @(posedge clk);
      cmp1VectorAck <= 1'b0;
      rd(3'h3, 8'h28, "ack no enable");
      wr(3'h5, 8'h60);
      @(posedge clk);
      cmp1VectorAck <= 1'b1;
      @(posedge clk);
      cmp1VectorAck <= 1'b0;
      rd(3'h3, 8'h08, "ack enabled");
      wr(3'h4, 8'h40);
      rd(3'h4, 8'h40, "cmp0 control");
      @(posedge clk);
      cmpOut <= 4'h9;
      tick(8);
      rd(3'h3, 8'h19, "cmp0 toggle");
      @(posedge clk);
      cmp0VectorAck <= 1'b1;
      @(posedge clk);
      cmp0VectorAck <= 1'b0;
      rd(3'h3, 8'h09, "cmp0 ack");
      rd(3'h1, 8'h01, "high readback");
      rd(3'h2, 8'h71, "low readback");
      // wait out the window so a queued edge would show
      tick(`CONV_CYCLES);
      check("final count", 10'(expUpd + 1), 10'(updates));
      $display("test comparators done");
      give_verdict();
   end
endmodule // dac_trigger_and_update_control_test

`default_nettype wire
